//--- src/dtsp_top.sv
/*
 * Display and touch serial host port: display byte receiver with an
 * 8-word FIFO toward the display controller, and a touch serial shifter
 * with report interrupt. Assumes the host serial clocks stay below the
 * core clock rate needed for sampling (touch clock under about 2.5 MHz);
 * the display clock is its own domain. I2C framing is not decoded here.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dtsp_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } dtsp_fifo_st_t;

    dtsp_fifo_st_t s_ff, nxt_s;
    logic          push;
    logic          pop;

    // Flags come straight from the occupancy count, so full really stalls.
    assign in_ready  = (s_ff.cnt != (AW+1)'(D));
    assign out_valid = (s_ff.cnt != '0);
    assign out_data  = s_ff.mem[s_ff.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and storage update.
    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data;
            nxt_s.wp           = s_ff.wp + AW'(1);
        end
        if (pop) begin
            nxt_s.rp = s_ff.rp + AW'(1);
        end
        nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule // dtsp_fifo

////////////////////////////////////////////////////////////////////////////////
module dtsp_top (
    // Core clock and master reset
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    // Protocol selection straps
    input  wire logic                          protocol_select_a,
    input  wire logic                          protocol_select_b,
    // Display port pins
    input  wire logic                          display_sclk,
    input  wire logic                          display_select_n,
    input  wire logic                          display_dc,
    input  wire logic                          display_sda_in,
    output logic                               display_sda_out,
    output logic                               display_sda_oe,
    // Display byte stream toward the controller
    output logic                               disp_valid,
    input  wire logic                          disp_ready,
    output logic [dtsp_pkg::BYTE_BITS-1:0]     disp_data,
    output logic                               disp_is_cmd,
    output logic                               disp_busy,
    output logic                               disp_overflow,
    output logic                               slave_address_low_bit,
    // Touch port pins
    input  wire logic                          touch_reset_n,
    input  wire logic                          touch_select_n,
    input  wire logic                          touch_sclk,
    input  wire logic                          serial_data_input,
    output logic                               serial_data_output,
    output logic                               serial_data_output_oe,
    output logic                               touch_irq,
    // Touch controller side
    input  wire logic                          touch_report_valid,
    output logic                               touch_report_ready,
    input  wire logic [dtsp_pkg::BYTE_BITS-1:0] touch_report_data,
    output logic                               touch_rx_valid,
    output logic [dtsp_pkg::BYTE_BITS-1:0]     touch_rx_data
);
    import dtsp_pkg::*;

    // Link-domain state: frame part cleared by the select, word part kept.
    typedef struct packed {
        logic [CNT_W-1:0]     cnt;
        logic [BYTE_BITS-2:0] sh;
    } dtsp_lframe_t;

    typedef struct packed {
        logic [WORD_W-1:0] hold;
        logic              tgl;
    } dtsp_lword_t;

    // Core-domain state.
    typedef struct packed {
        logic [2:0]           tgl_s;
        logic [1:0]           dc_s;
        logic [1:0]           dmode_s;
        logic [1:0]           tmode_s;
        logic [1:0]           trst_s;
        logic [1:0]           tsel_s;
        logic [2:0]           tclk_s;
        logic [1:0]           tsdi_s;
        dtsp_tstate_t         tstate;
        logic [CNT_W-1:0]     tcnt;
        logic [BYTE_BITS-1:0] trx;
        logic [BYTE_BITS-1:0] ttx;
        logic [BYTE_BITS-1:0] report;
        logic                 pending;
        logic                 rx_valid;
        logic [BYTE_BITS-1:0] rx_data;
        logic                 sdo;
        logic                 ovf;
        logic                 sa0;
    } dtsp_core_t;

    logic [1:0]       rst_sync_ff;
    logic             rst_n;
    logic             frame_rst_n;
    dtsp_lframe_t     lf_ff, nxt_lf;
    dtsp_lword_t      lw_ff, nxt_lw;
    dtsp_core_t       c_ff, nxt_c;
    logic             byte_evt;
    logic             disp_i2c;
    logic             fifo_in_ready;
    logic             fifo_push;
    logic [WORD_W-1:0] fifo_out;
    logic             touch_rst;
    logic             t_rise;
    logic             t_fall;
    logic             t_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Master reset released through two flops; assertion stays asynchronous.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= SYNC_ZERO;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // Display link domain. A deselected port holds its bit counter cleared,
    // so an aborted byte never leaks into the next frame.
    assign frame_rst_n = arst_n && !display_select_n;

    // Shift MSB first; the select level is taken with the last bit.
    always_comb begin
        nxt_lf     = lf_ff;
        nxt_lw     = lw_ff;
        nxt_lf.cnt = lf_ff.cnt + CNT_ONE;
        nxt_lf.sh  = {lf_ff.sh[BYTE_BITS-3:0], display_sda_in};
        if (lf_ff.cnt == CNT_LAST) begin
            nxt_lw.hold = {display_dc, lf_ff.sh, display_sda_in};
            nxt_lw.tgl  = !lw_ff.tgl;
        end
    end

    always_ff @(posedge display_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            lf_ff <= '0;
        end else begin
            lf_ff <= nxt_lf;
        end
    end

    // The toggle must survive deselect, or the core would see a false byte.
    always_ff @(posedge display_sclk or negedge arst_n) begin
        if (!arst_n) begin
            lw_ff <= '0;
        end else begin
            lw_ff <= nxt_lw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core-domain event decode. The hold word is stable for a whole byte
    // time after the toggle moves, which is why it may be read directly.
    assign byte_evt  = c_ff.tgl_s[2] != c_ff.tgl_s[1];
    assign disp_i2c  = c_ff.dmode_s[1];
    assign fifo_push = byte_evt && !disp_i2c;
    assign touch_rst = !c_ff.trst_s[1];
    assign t_sel     = !c_ff.tsel_s[1] && !c_ff.tmode_s[1];
    assign t_rise    = c_ff.tclk_s[1] && !c_ff.tclk_s[2];
    assign t_fall    = !c_ff.tclk_s[1] && c_ff.tclk_s[2];

    // Synchronisers, touch shifter and display side flags.
    always_comb begin
        nxt_c          = c_ff;
        nxt_c.tgl_s    = {c_ff.tgl_s[1:0], lw_ff.tgl};
        nxt_c.dc_s     = {c_ff.dc_s[0], display_dc};
        nxt_c.dmode_s  = {c_ff.dmode_s[0], protocol_select_a};
        nxt_c.tmode_s  = {c_ff.tmode_s[0], protocol_select_b};
        nxt_c.trst_s   = {c_ff.trst_s[0], touch_reset_n};
        nxt_c.tsel_s   = {c_ff.tsel_s[0], touch_select_n};
        nxt_c.tclk_s   = {c_ff.tclk_s[1:0], touch_sclk};
        nxt_c.tsdi_s   = {c_ff.tsdi_s[0], serial_data_input};
        nxt_c.rx_valid = 1'b0;
        nxt_c.sa0      = disp_i2c && c_ff.dc_s[1];
        if (fifo_push && !fifo_in_ready) begin
            nxt_c.ovf = 1'b1;
        end
        unique case (c_ff.tstate)
            DTSP_T_IDLE: begin
                if (t_sel) begin
                    nxt_c.tstate = DTSP_T_ACTIVE;
                    nxt_c.tcnt   = CNT_ZERO;
                    nxt_c.ttx    = c_ff.pending ? c_ff.report : BYTE_ZERO;
                    nxt_c.sdo    = c_ff.pending ? c_ff.report[BYTE_BITS-1] : 1'b0;
                end
            end
            DTSP_T_ACTIVE: begin
                if (!t_sel) begin
                    nxt_c.tstate = DTSP_T_IDLE;
                end else if (t_rise) begin
                    nxt_c.trx  = {c_ff.trx[BYTE_BITS-2:0], c_ff.tsdi_s[1]};
                    nxt_c.tcnt = c_ff.tcnt + CNT_ONE;
                    if (c_ff.tcnt == CNT_LAST) begin
                        nxt_c.rx_valid = 1'b1;
                        nxt_c.rx_data  = {c_ff.trx[BYTE_BITS-2:0], c_ff.tsdi_s[1]};
                        nxt_c.pending  = 1'b0;
                    end
                end else if (t_fall) begin
                    nxt_c.ttx = {c_ff.ttx[BYTE_BITS-2:0], 1'b0};
                    nxt_c.sdo = c_ff.ttx[BYTE_BITS-2];
                end
            end
        endcase
        // A report is latched whenever none is pending. It sits after the
        // shifter so a new report wins over a byte-end clear in one cycle.
        if (touch_report_valid && !c_ff.pending) begin
            nxt_c.report  = touch_report_data;
            nxt_c.pending = 1'b1;
        end
        // Touch reset clears only touch state; the display side runs on.
        if (touch_rst) begin
            nxt_c.tstate   = DTSP_T_IDLE;
            nxt_c.tcnt     = CNT_ZERO;
            nxt_c.pending  = 1'b0;
            nxt_c.rx_valid = 1'b0;
            nxt_c.sdo      = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            c_ff <= '0;
        end else begin
            c_ff <= nxt_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte FIFO toward the display controller; it cannot stall the host, so
    // a full FIFO shows as busy and a lost byte sets the overflow flag.
    dtsp_fifo #(
        .W (WORD_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (lw_ff.hold),
        .out_valid (disp_valid),
        .out_ready (disp_ready),
        .out_data  (fifo_out)
    );

    // Output assignments.
    assign disp_data             = fifo_out[BYTE_BITS-1:0];
    assign disp_is_cmd           = !fifo_out[DC_POS];
    assign disp_busy             = !fifo_in_ready;
    assign disp_overflow         = c_ff.ovf;
    assign slave_address_low_bit = c_ff.sa0;
    assign display_sda_out       = 1'b0; // I2C answer path is not built.
    assign display_sda_oe        = 1'b0;
    assign serial_data_output    = c_ff.sdo;
    assign serial_data_output_oe = (c_ff.tstate == DTSP_T_ACTIVE) && t_sel;
    assign touch_irq             = c_ff.pending;
    assign touch_report_ready    = !c_ff.pending;
    assign touch_rx_valid        = c_ff.rx_valid;
    assign touch_rx_data         = c_ff.rx_data;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the behaviour above.
    AST_DATA_BYTE: assert property (@(posedge clock) disable iff (!rst_n)
        fifo_push && !disp_valid && lw_ff.hold[DC_POS]
        |=> disp_valid && !disp_is_cmd && disp_data == $past(lw_ff.hold[BYTE_BITS-1:0]))
        else $error("Data byte not presented as data.");
    AST_CMD_BYTE: assert property (@(posedge clock) disable iff (!rst_n)
        fifo_push && !disp_valid && !lw_ff.hold[DC_POS] |=> disp_valid && disp_is_cmd)
        else $error("Command byte not presented as command.");
    AST_I2C_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
        disp_i2c && c_ff.dc_s[1] |=> slave_address_low_bit)
        else $error("Address bit does not follow select in I2C mode.");
    AST_I2C_NO_BYTE: assert property (@(posedge clock) disable iff (!rst_n)
        disp_i2c && !disp_valid |=> !disp_valid)
        else $error("Byte queued in I2C mode.");
    AST_TOUCH_RST: assert property (@(posedge clock) disable iff (!rst_n)
        !c_ff.trst_s[1] |=> !touch_irq && !touch_rx_valid && !serial_data_output_oe)
        else $error("Touch state survived touch reset.");
    AST_TOUCH_DESEL: assert property (@(posedge clock) disable iff (!rst_n)
        c_ff.tsel_s[1] [*2] |=> !touch_rx_valid && !serial_data_output_oe)
        else $error("Touch port active while deselected.");
    AST_TOUCH_BYTE: assert property (@(posedge clock) disable iff (!rst_n)
        touch_rx_valid |-> $past(c_ff.tcnt) == CNT_LAST && $past(t_rise))
        else $error("Touch byte ended off the eighth edge.");
    AST_IRQ_SET: assert property (@(posedge clock) disable iff (!rst_n)
        touch_report_valid && touch_report_ready && c_ff.trst_s[1] |=> touch_irq)
        else $error("Interrupt missing after report.");
    AST_DISP_DESEL: assert property (@(posedge clock) disable iff (!rst_n)
        display_select_n && $past(display_select_n) |-> lf_ff.cnt == CNT_ZERO)
        else $error("Display bit count moved while deselected.");
    AST_MASTER_RST: assert property (@(posedge clock)
        !arst_n |=> !disp_valid && !touch_irq && !disp_overflow)
        else $error("State survived master reset.");
    AST_LAST_BIT: assert property (@(posedge display_sclk) disable iff (!frame_rst_n)
        lf_ff.cnt == CNT_LAST |=> lw_ff.tgl != $past(lw_ff.tgl))
        else $error("Byte not handed over on eighth bit.");
endmodule // dtsp_top

//--- src/dtsp_pkg.sv
/*
 * Shared constants and types of the display and touch serial host port.
 * Assumes a 20 MHz core clock and serial clocks generated by the host.
 */
// Function
// - High select level marks serial byte as data
// - Low select level sends byte to commands
// - In I2C mode select sets address bit
// - Touch reset low initialises touch logic only
// - Touch port answers only while selected low
// - Touch serial uses data out, in, clock
// - Interrupt output flags pending touch report
// - Display accepts transfers only while selected low
// - Master reset low initialises display logic
package dtsp_pkg;
    localparam int          BYTE_BITS  = 8;
    localparam int          CNT_W      = 3;
    localparam logic [2:0]  CNT_ZERO   = 3'h0;
    localparam logic [2:0]  CNT_LAST   = 3'h7;
    localparam logic [2:0]  CNT_ONE    = 3'h1;
    localparam int          FIFO_DEPTH = 8;
    localparam int          WORD_W     = 9;
    localparam int          DC_POS     = 8;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [8:0]  WORD_ZERO  = 9'h000;
    localparam logic [1:0]  SYNC_ZERO  = 2'h0;

    // Touch shifter sequencing.
    typedef enum logic { DTSP_T_IDLE, DTSP_T_ACTIVE } dtsp_tstate_t;
endpackage

//--- verif/dtsp_host_model.sv
/*
 * Host model: drives display and touch serial frames, captures touch reply.
 * Assumes one caller process at a time and the core clock for touch pacing.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dtsp_host_model (
    // Core clock
    input  wire logic clock,
    // Display port pins
    output logic      display_sclk,
    output logic      display_select_n,
    output logic      display_dc,
    output logic      display_sda_in,
    // Touch port pins
    output logic      touch_select_n,
    output logic      touch_sclk,
    output logic      serial_data_input,
    input  wire logic serial_data_output
);
    // Both links start deselected with their clocks standing low.
    initial begin
        display_sclk = 1'b0;
        display_select_n = 1'b1;
        display_dc = 1'b1;
        display_sda_in = 1'b0;
        touch_select_n = 1'b1;
        touch_sclk = 1'b0;
        serial_data_input = 1'b0;
    end

    // Display frame at a 64 ns link period; the link clock runs only inside it.
    task automatic disp_send(input logic [7:0] b, input logic dc, input int nbits,
                             input logic sel);
        #13;
        display_dc = dc;
        display_select_n = ~sel;
        #20;
        for (int i = 0; i < nbits; i++) begin
            display_sda_in = b[7-i];
            #32 display_sclk = 1'b1;
            #32 display_sclk = 1'b0;
        end
        #20;
        display_select_n = 1'b1;
        // A released line shows the inverse, so a stale bit is never read as valid.
        display_sda_in = ~display_sda_in;
    endtask

    // Touch byte; the clock stays low for 6 cycles so the reply bit has settled.
    task automatic touch_xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
        @(posedge clock);
        touch_select_n <= ~sel;
        repeat (6) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            serial_data_input <= tx[7-i];
            repeat (6) @(posedge clock);
            rx[7-i] = serial_data_output;
            touch_sclk <= 1'b1;
            repeat (4) @(posedge clock);
            touch_sclk <= 1'b0;
        end
        repeat (6) @(posedge clock);
        touch_select_n <= 1'b1;
        serial_data_input <= ~serial_data_input;
    endtask
endmodule // dtsp_host_model

//--- verif/tb_dtsp_top.sv
/*
 * Self-checking testbench of the display and touch serial host port.
 * Assumes the host model drives the pins and the bench plays both controllers.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tb_dtsp_top;
    import dtsp_pkg::*;

    logic       clock, arst_n, protocol_select_a, protocol_select_b;
    logic       display_sclk, display_select_n, display_dc, display_sda_in;
    logic       display_sda_out, display_sda_oe, disp_valid, disp_ready;
    logic [7:0] disp_data, touch_report_data, touch_rx_data, rx, rx_last;
    logic       disp_is_cmd, disp_busy, disp_overflow, slave_address_low_bit;
    logic       touch_reset_n, touch_select_n, touch_sclk, serial_data_input;
    logic       serial_data_output, serial_data_output_oe, touch_irq;
    logic       touch_report_valid, touch_report_ready, touch_rx_valid;
    int         mismatches, check_count, rx_count, cnt;

    dtsp_top dut_u (.clock(clock), .arst_n(arst_n), .protocol_select_a(protocol_select_a),
        .protocol_select_b(protocol_select_b), .display_sclk(display_sclk),
        .display_select_n(display_select_n), .display_dc(display_dc),
        .display_sda_in(display_sda_in), .display_sda_out(display_sda_out),
        .display_sda_oe(display_sda_oe), .disp_valid(disp_valid), .disp_ready(disp_ready),
        .disp_data(disp_data), .disp_is_cmd(disp_is_cmd), .disp_busy(disp_busy),
        .disp_overflow(disp_overflow), .slave_address_low_bit(slave_address_low_bit),
        .touch_reset_n(touch_reset_n), .touch_select_n(touch_select_n),
        .touch_sclk(touch_sclk), .serial_data_input(serial_data_input),
        .serial_data_output(serial_data_output), .touch_irq(touch_irq),
        .serial_data_output_oe(serial_data_output_oe),
        .touch_report_valid(touch_report_valid), .touch_report_ready(touch_report_ready),
        .touch_report_data(touch_report_data), .touch_rx_valid(touch_rx_valid),
        .touch_rx_data(touch_rx_data));

    dtsp_host_model host_u (.clock(clock), .display_sclk(display_sclk),
        .display_select_n(display_select_n), .display_dc(display_dc),
        .display_sda_in(display_sda_in), .touch_select_n(touch_select_n),
        .touch_sclk(touch_sclk), .serial_data_input(serial_data_input),
        .serial_data_output(serial_data_output));

    // Core clock at 20 MHz.
    always #25 clock = ~clock;

    // The received-byte strobe lasts one cycle, so it is counted as it passes.
    always @(posedge clock) begin
        if (touch_rx_valid === 1'b1) begin
            rx_count <= rx_count + 1;
            rx_last <= touch_rx_data;
        end
    end

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Waits a bounded time for the head byte, compares it, then pops it.
    task automatic take(input logic [7:0] b, input logic is_cmd);
        for (int n = 0; n < 40 && disp_valid !== 1'b1; n++) settle(1);
        check("disp_valid", disp_valid, 1'b1);
        check("disp_data", disp_data, b);
        check("disp_is_cmd", disp_is_cmd, is_cmd);
        @(posedge clock);
        disp_ready <= 1'b1;
        @(posedge clock);
        disp_ready <= 1'b0;
        #1;
    endtask

    task automatic offer(input logic [7:0] b);
        @(posedge clock);
        touch_report_valid <= 1'b1;
        touch_report_data <= b;
        @(posedge clock);
        touch_report_valid <= 1'b0;
        settle(2);
        check("touch_irq", touch_irq, 1'b1);
        check("report_ready", touch_report_ready, 1'b0);
    endtask

    task automatic t_reset();
        check("disp_valid", disp_valid, 1'b0);
        check("disp_busy", disp_busy, 1'b0);
        check("overflow", disp_overflow, 1'b0);
        check("touch_irq", touch_irq, 1'b0);
        check("sdo_oe", serial_data_output_oe, 1'b0);
        check("sda_oe", display_sda_oe, 1'b0);
        check("sda_out", display_sda_out, 1'b0);
        $display("test reset done");
    endtask

    // Data then command back to back, read out in order.
    task automatic t_data_cmd();
        host_u.disp_send(8'hA5, 1'b1, 8, 1'b1);
        host_u.disp_send(8'h3C, 1'b0, 8, 1'b1);
        take(8'hA5, 1'b0);
        take(8'h3C, 1'b1);
        $display("test data and command done");
    endtask

    // A partial byte and a deselected byte must leave no trace.
    task automatic t_select();
        host_u.disp_send(8'hFF, 1'b1, 4, 1'b1);
        host_u.disp_send(8'h81, 1'b1, 8, 1'b0);
        host_u.disp_send(8'h42, 1'b0, 8, 1'b1);
        take(8'h42, 1'b1);
        settle(10);
        check("disp_valid", disp_valid, 1'b0);
        $display("test select done");
    endtask

    // Fill with the consumer stalled, overflow once, then drain in order.
    task automatic t_fifo();
        for (int i = 0; i < 8; i++) host_u.disp_send(8'h10 + i[7:0], i[0], 8, 1'b1);
        settle(10);
        check("disp_busy", disp_busy, 1'b1);
        check("overflow", disp_overflow, 1'b0);
        host_u.disp_send(8'hEE, 1'b1, 8, 1'b1);
        settle(10);
        check("overflow", disp_overflow, 1'b1);
        for (int i = 0; i < 8; i++) take(8'h10 + i[7:0], ~i[0]);
        settle(3);
        check("disp_valid", disp_valid, 1'b0);
        check("disp_busy", disp_busy, 1'b0);
        $display("test fifo done");
    endtask

    // In I2C mode the select level becomes the address bit and bytes are dropped.
    task automatic t_i2c();
        @(posedge clock);
        protocol_select_a <= 1'b1;
        protocol_select_b <= 1'b1;
        settle(6);
        host_u.disp_send(8'h77, 1'b1, 8, 1'b1);
        settle(8);
        check("sa0", slave_address_low_bit, 1'b1);
        host_u.disp_send(8'h77, 1'b0, 8, 1'b1);
        settle(8);
        check("sa0", slave_address_low_bit, 1'b0);
        check("disp_valid", disp_valid, 1'b0);
        cnt = rx_count;
        host_u.touch_xfer(8'h5A, 1'b1, rx);
        settle(8);
        check("rx_count", rx_count[8:0], cnt[8:0]);
        @(posedge clock);
        protocol_select_a <= 1'b0;
        protocol_select_b <= 1'b0;
        settle(6);
        $display("test i2c done");
    endtask

    // Report out while a byte comes in; deselected traffic is ignored.
    task automatic t_touch();
        offer(8'hC3);
        cnt = rx_count;
        host_u.touch_xfer(8'h5A, 1'b1, rx);
        settle(8);
        check("touch_reply", rx, 8'hC3);
        check("rx_count", rx_count[8:0], cnt[8:0] + 9'h001);
        check("rx_data", rx_last, 8'h5A);
        check("touch_irq", touch_irq, 1'b0);
        check("sdo_oe", serial_data_output_oe, 1'b0);
        host_u.touch_xfer(8'hA1, 1'b0, rx);
        settle(8);
        check("rx_count", rx_count[8:0], cnt[8:0] + 9'h001);
        $display("test touch done");
    endtask

    // Touch reset drops the pending report and leaves the display side alone.
    task automatic t_touch_reset();
        offer(8'h99);
        @(posedge clock);
        touch_reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        touch_reset_n <= 1'b1;
        settle(6);
        check("touch_irq", touch_irq, 1'b0);
        check("overflow", disp_overflow, 1'b1);
        host_u.touch_xfer(8'h00, 1'b1, rx);
        check("touch_reply", rx, 8'h00);
        $display("test touch reset done");
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (30000) @(posedge clock);
        mismatches++;
        final_report();
    end

    initial begin
        {clock, arst_n, protocol_select_a, protocol_select_b, disp_ready} = 5'h00;
        {touch_reset_n, touch_report_valid, touch_report_data} = 10'h000;
        {mismatches, check_count, rx_count} = {32'h0, 32'h0, 32'h0};
        rx_last = 8'h00;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        touch_reset_n <= 1'b1;
        settle(8);
        t_reset();
        t_data_cmd();
        t_select();
        t_fifo();
        t_i2c();
        t_touch();
        t_touch_reset();
        final_report();
    end
endmodule // tb_dtsp_top
